// ---- xor_skip_pkg.sv ----
// package: shared constants, opcodes and types for the xor / test-skip execution block
package xor_skip_pkg;

   // quarter phases of one instruction cycle
   typedef enum logic [1:0] {
      Q1_DECODE,
      Q2_READ,
      Q3_PROCESS,
      Q4_WRITE
   } phase_t;

   // wishbone register byte offsets
   localparam logic [7:0] CTRL_OFS   = 8'h00; // bit0 extended set enable
   localparam logic [7:0] ACC_OFS    = 8'h04; // working accumulator
   localparam logic [7:0] STATUS_OFS = 8'h08; // zero and negative flags
   localparam logic [7:0] BANK_OFS   = 8'h0c; // bank select pointer
   localparam logic [7:0] INDEX_OFS  = 8'h10; // base for indexed literal offset
   localparam logic [7:0] PC_OFS     = 8'h14; // program counter
   localparam logic [7:0] MADDR_OFS  = 8'h18; // data memory window address
   localparam logic [7:0] MDATA_OFS  = 8'h1c; // data memory window data

   // field positions
   localparam int CTRL_EXT_BIT = 0;
   localparam int ZERO_BIT     = 0;
   localparam int NEG_BIT      = 1;
   localparam int DEST_BIT     = 9;
   localparam int ACCESS_BIT   = 8;
   localparam int SIGN_BIT     = 7;

   // opcode patterns, compared against the upper instruction bits
   localparam logic [6:0] OP_TEST_SKIP  = 7'h33; // 0110 011a
   localparam logic [7:0] OP_XOR_LIT    = 8'h0a; // 0000 1010
   localparam logic [5:0] OP_XOR_REG    = 6'h06; // 0001 10da

   // first words of two-word instructions
   localparam logic [3:0] OP_MOVE_FF    = 4'hc;
   localparam logic [6:0] OP_CALL       = 7'h76;
   localparam logic [7:0] OP_LOAD_PTR   = 8'hee;
   localparam logic [7:0] OP_GOTO       = 8'hef;
   localparam logic [7:0] OP_MOVE_STACK = 8'heb;

   // access bank split: low part below, special area from here up
   localparam logic [7:0] ACCESS_SPLIT  = 8'h60;
   localparam logic [7:0] INDEX_LIMIT   = 8'h5f;
   localparam logic [7:0] ZERO_BYTE     = 8'h00;

   // skip length in instruction cycles
   localparam logic [1:0] SKIP_ONE      = 2'h1;
   localparam logic [1:0] SKIP_TWO      = 2'h2;
   localparam logic [1:0] SKIP_NONE     = 2'h0;

endpackage : xor_skip_pkg

// ---- data_ram.sv ----
// data memory: one write port, two read ports with registered read data
module data_ram #(
   parameter int AW = 12,
   parameter int DW = 8
) (
   input  wire logic          clk_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [DW-1:0] wdata_i,
   input  wire logic [AW-1:0] a_addr_i,
   output logic      [DW-1:0] a_data_o,
   input  wire logic [AW-1:0] b_addr_i,
   output logic      [DW-1:0] b_data_o
);

   logic [DW-1:0] mem [2**AW]; // storage, no reset: contents are software's business

   // read first, reads return the old word on a same-address collision
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      a_data_o <= mem[a_addr_i];
      b_data_o <= mem[b_addr_i];
   end

endmodule : data_ram

// ---- xor_skip_exec.sv ----
// execution unit for the test-skip-if-zero and two exclusive-or instructions
//
// Contract
// - test-skip reads register, zero discards next instruction
// - skip costs one nop cycle, two for two-word
// - pc passes next instruction only when zero
// - xor literal into accumulator, update negative, zero
// - xor accumulator with register, update negative, zero
// - destination bit: clear accumulator, set register
// - access bit clear access bank, set bank pointer
// - extended set, access clear, f<=5Fh uses indexing
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
module xor_skip_exec
   import xor_skip_pkg::*;
#(
   parameter int BANK_W = 4,   // bank select pointer width
   parameter int PC_W   = 16,  // program counter width
   parameter int ADR_W  = 8    // wishbone byte address width
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // wishbone classic slave
   input  wire logic             wb_cyc_i,
   input  wire logic             wb_stb_i,
   input  wire logic             wb_we_i,
   input  wire logic [ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]       wb_sel_i,
   input  wire logic [31:0]      wb_dat_i,
   output logic      [31:0]      wb_dat_o,
   output logic                  wb_ack_o,
   // instruction issue from the fetch pipeline
   input  wire logic             instr_valid_i,
   input  wire logic [15:0]      instr_i,
   input  wire logic [15:0]      follow_word_i,
   output logic                  instr_ready_o,
   output logic      [1:0]       phase_o,
   output logic                  skip_active_o,
   output logic      [PC_W-1:0]  pc_o
);

   localparam int AW = BANK_W + 8; // data address width

   // whole module state
   typedef struct packed {
      phase_t            phase;      // current quarter phase
      logic              ready;      // ready for a new instruction
      logic              busy;       // an instruction is in flight
      logic [15:0]       instr;      // latched instruction word
      logic              follow_two; // following instruction has two words
      logic [1:0]        skip_left;  // nop cycles still owed
      logic              skip_act;   // skip flag kept in a flop so the output carries no logic
      logic [AW-1:0]     addr;       // resolved data address
      logic [7:0]        operand;    // operand taken in processing
      logic [7:0]        result;     // processed value
      logic [7:0]        acc;        // working accumulator
      logic              neg;        // negative flag
      logic              zero;       // zero flag
      logic [BANK_W-1:0] bank;       // bank select pointer
      logic              ext_en;     // extended instruction set enable
      logic [AW-1:0]     index;      // indexed addressing base
      logic [PC_W-1:0]   pc;         // program counter
      logic [AW-1:0]     maddr;      // memory window address
      logic              ack;        // bus acknowledge
      logic [31:0]       dat;        // bus read data
   } state_t;

   state_t st;       // registered state
   state_t next_st;  // next state

   logic [7:0] mem_rdata;  // core read port data
   logic [7:0] win_rdata;  // window read port data
   logic       core_we;    // core writes a register this cycle
   logic       win_we;     // bus writes through the window
   logic       mem_we;     // merged write enable
   logic [AW-1:0] mem_waddr; // merged write address
   logic [7:0] mem_wdata;  // merged write data
   logic       bus_req;    // fresh bus request

   // recognises the first word of a two-word instruction
   function automatic logic is_two_word(input logic [15:0] w);
      is_two_word = (w[15:12] == OP_MOVE_FF) || (w[15:9] == OP_CALL) ||
                    (w[15:8] == OP_LOAD_PTR) || (w[15:8] == OP_GOTO) ||
                    (w[15:8] == OP_MOVE_STACK);
   endfunction : is_two_word

   // forms the data address from the register field and access bit
   function automatic logic [AW-1:0] form_address(input logic [15:0] w, input logic ext,
                                                  input logic [BANK_W-1:0] bsel,
                                                  input logic [AW-1:0] base);
      logic [7:0] f;
      f = w[7:0];
      if (w[ACCESS_BIT]) begin
         form_address = {bsel, f};
      end else if (ext && (f <= INDEX_LIMIT)) begin
         form_address = base + AW'(f);
      end else if (f < ACCESS_SPLIT) begin
         form_address = {{BANK_W{1'b0}}, f};
      end else begin
         form_address = {{BANK_W{1'b1}}, f};
      end
   endfunction : form_address

   // merges a byte-lane write into an existing register value
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                         input logic [3:0] sel);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = sel[i] ? wr[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction : merge

   // core write happens only in the write phase of a register-destined xor
   assign core_we  = st.busy && (st.phase == Q4_WRITE) &&
                     (st.instr[15:10] == OP_XOR_REG) && st.instr[DEST_BIT];
   assign bus_req  = wb_cyc_i && wb_stb_i && !st.ack;
   // the window write waits while the core owns the write port
   assign win_we   = bus_req && wb_we_i && (wb_adr_i == ADR_W'(MDATA_OFS)) && !core_we && wb_sel_i[0];
   assign mem_we   = core_we || win_we;
   assign mem_waddr = core_we ? st.addr : st.maddr;
   assign mem_wdata = core_we ? st.result : wb_dat_i[7:0];

   // banked data memory, read in the second quarter
   data_ram #(
      .AW (AW),
      .DW (8)
   ) u_ram (
      .clk_i    (clk_i),
      .we_i     (mem_we),
      .waddr_i  (mem_waddr),
      .wdata_i  (mem_wdata),
      .a_addr_i (st.addr),
      .a_data_o (mem_rdata),
      .b_addr_i (st.maddr),
      .b_data_o (win_rdata)
   );

   // next-state logic: phase sequencing, execution and bus slave
   always_comb begin
      logic [31:0] wr;
      logic        blocked;
      wr      = '0;
      blocked = 1'b0;
      next_st = st;
      next_st.ack = 1'b0;

      // quarter phases roll over every clock
      case (st.phase)
         Q1_DECODE: begin
            next_st.phase = Q2_READ;
            if (st.ready && instr_valid_i) begin
               next_st.busy       = 1'b1;
               next_st.instr      = instr_i;
               next_st.follow_two = is_two_word(follow_word_i);
               next_st.addr       = form_address(instr_i, st.ext_en, st.bank, st.index);
            end
         end
         Q2_READ: begin
            next_st.phase = Q3_PROCESS; // memory read issued from the latched address
         end
         Q3_PROCESS: begin
            next_st.phase = Q4_WRITE;
            if (st.instr[15:8] == OP_XOR_LIT) begin
               next_st.operand = st.instr[7:0];
            end else begin
               next_st.operand = mem_rdata;
            end
            next_st.result = st.acc ^ next_st.operand;
         end
         default: begin
            next_st.phase = Q1_DECODE;
            if (st.busy) begin
               next_st.busy = 1'b0;
               next_st.pc   = st.pc + PC_W'(SKIP_ONE);
               if (st.instr[15:9] == OP_TEST_SKIP) begin
                  if (st.operand == ZERO_BYTE) begin
                     // discard the already fetched word(s), run nops in their place
                     next_st.skip_left = st.follow_two ? SKIP_TWO : SKIP_ONE;
                     next_st.pc = st.pc + PC_W'(SKIP_ONE) + PC_W'(next_st.skip_left);
                  end
               end else if (st.instr[15:8] == OP_XOR_LIT) begin
                  next_st.acc  = st.result;
                  next_st.neg  = st.result[SIGN_BIT];
                  next_st.zero = (st.result == ZERO_BYTE);
               end else if (st.instr[15:10] == OP_XOR_REG) begin
                  if (!st.instr[DEST_BIT]) begin
                     next_st.acc = st.result;
                  end
                  next_st.neg  = st.result[SIGN_BIT];
                  next_st.zero = (st.result == ZERO_BYTE);
               end
            end else if (st.skip_left != SKIP_NONE) begin
               next_st.skip_left = st.skip_left - SKIP_ONE;
            end
         end
      endcase

      // bus slave; core updates above take priority in the same cycle
      if (bus_req) begin
         blocked = wb_we_i && (wb_adr_i == ADR_W'(MDATA_OFS)) && core_we;
         next_st.ack = !blocked;
         next_st.dat = '0;
         if (wb_adr_i == ADR_W'(CTRL_OFS)) begin
            next_st.dat[CTRL_EXT_BIT] = st.ext_en;
            if (wb_we_i && wb_sel_i[0]) begin
               next_st.ext_en = wb_dat_i[CTRL_EXT_BIT];
            end
         end else if (wb_adr_i == ADR_W'(ACC_OFS)) begin
            next_st.dat[7:0] = st.acc;
            if (wb_we_i && wb_sel_i[0] && !(st.busy && st.phase == Q4_WRITE)) begin
               next_st.acc = wb_dat_i[7:0];
            end
         end else if (wb_adr_i == ADR_W'(STATUS_OFS)) begin
            next_st.dat[ZERO_BIT] = st.zero;
            next_st.dat[NEG_BIT]  = st.neg;
            if (wb_we_i && wb_sel_i[0] && !(st.busy && st.phase == Q4_WRITE)) begin
               next_st.zero = wb_dat_i[ZERO_BIT];
               next_st.neg  = wb_dat_i[NEG_BIT];
            end
         end else if (wb_adr_i == ADR_W'(BANK_OFS)) begin
            next_st.dat[BANK_W-1:0] = st.bank;
            if (wb_we_i && wb_sel_i[0]) begin
               next_st.bank = wb_dat_i[BANK_W-1:0];
            end
         end else if (wb_adr_i == ADR_W'(INDEX_OFS)) begin
            next_st.dat[AW-1:0] = st.index;
            wr = merge(32'(st.index), wb_dat_i, wb_sel_i);
            if (wb_we_i) begin
               next_st.index = wr[AW-1:0];
            end
         end else if (wb_adr_i == ADR_W'(PC_OFS)) begin
            next_st.dat[PC_W-1:0] = st.pc;
            wr = merge(32'(st.pc), wb_dat_i, wb_sel_i);
            // pc writes only land between instructions
            if (wb_we_i && !st.busy) begin
               next_st.pc = wr[PC_W-1:0];
            end
         end else if (wb_adr_i == ADR_W'(MADDR_OFS)) begin
            next_st.dat[AW-1:0] = st.maddr;
            wr = merge(32'(st.maddr), wb_dat_i, wb_sel_i);
            if (wb_we_i) begin
               next_st.maddr = wr[AW-1:0];
            end
         end else if (wb_adr_i == ADR_W'(MDATA_OFS)) begin
            next_st.dat[7:0] = win_rdata;
         end
         // unmapped addresses ack with zero data and no effect
      end

      // accept new work only at the decode quarter with no skip owed
      next_st.ready = (next_st.phase == Q1_DECODE) && (next_st.skip_left == SKIP_NONE);
      // registered copy of the owed-skip test, so skip_active_o is a plain flop output
      next_st.skip_act = (next_st.skip_left != SKIP_NONE);
   end

   // single state register, synchronous reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st       <= '0;
         st.phase <= Q1_DECODE;
         st.ready <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from the state register
   assign wb_ack_o      = st.ack;
   assign wb_dat_o      = st.dat;
   assign instr_ready_o = st.ready;
   assign phase_o       = st.phase;
   assign skip_active_o = st.skip_act;
   assign pc_o          = st.pc;

endmodule : xor_skip_exec

// ---- xor_skip_exec_sva.sv ----
// checker for the xor / test-skip execution block, bound to its ports
module xor_skip_exec_sva
   import xor_skip_pkg::*;
#(
   parameter int PC_W  = 16,
   parameter int ADR_W = 8
) (
   input wire logic             clk_i,
   input wire logic             rst_i,
   input wire logic             wb_cyc_i,
   input wire logic             wb_stb_i,
   input wire logic             wb_we_i,
   input wire logic [ADR_W-1:0] wb_adr_i,
   input wire logic [3:0]       wb_sel_i,
   input wire logic [31:0]      wb_dat_i,
   input wire logic [31:0]      wb_dat_o,
   input wire logic             wb_ack_o,
   input wire logic             instr_valid_i,
   input wire logic [15:0]      instr_i,
   input wire logic [15:0]      follow_word_i,
   input wire logic             instr_ready_o,
   input wire logic [1:0]       phase_o,
   input wire logic             skip_active_o,
   input wire logic [PC_W-1:0]  pc_o
);
   // words a skip must cover: two when the follower opens a two-word instruction
   function automatic logic [1:0] words(input logic [15:0] w);
      if (w[15:12] == OP_MOVE_FF || w[15:9] == OP_CALL || w[15:8] == OP_LOAD_PTR || w[15:8] == OP_GOTO ||
          w[15:8] == OP_MOVE_STACK) begin
         return SKIP_TWO;
      end
      return SKIP_ONE;
   endfunction : words
   wire logic take  = instr_ready_o && instr_valid_i;                  // instruction taken this edge
   wire logic tskip = take && instr_i[15:9] == OP_TEST_SKIP;           // test-skip taken
   wire logic txor  = take && (instr_i[15:8] == OP_XOR_LIT || instr_i[15:10] == OP_XOR_REG);
   // one domain only, so clock and reset are stated once
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");
   property p_ack_bound; wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:2] wb_ack_o; endproperty
   a_ack_bound: assert property (p_ack_bound) else $error("bus request not answered in time");
   property p_phase; 1'b1 |=> phase_o == 2'($past(phase_o) + 2'h1); endproperty
   a_phase: assert property (p_phase) else $error("quarter phase did not advance");
   property p_ready; instr_ready_o |-> phase_o == 2'h0 && !skip_active_o; endproperty
   a_ready: assert property (p_ready) else $error("ready outside an idle first quarter");
   property p_skip_cause; $rose(skip_active_o) |-> $past(tskip, 4); endproperty
   a_skip_cause: assert property (p_skip_cause) else $error("skip without a test instruction");
   property p_skip_one;
      $rose(skip_active_o) && words($past(follow_word_i, 4)) == SKIP_ONE |-> skip_active_o[*4] ##1 !skip_active_o;
   endproperty
   a_skip_one: assert property (p_skip_one) else $error("single-word skip length wrong");
   property p_skip_two;
      $rose(skip_active_o) && words($past(follow_word_i, 4)) == SKIP_TWO |-> skip_active_o[*8] ##1 !skip_active_o;
   endproperty
   a_skip_two: assert property (p_skip_two) else $error("two-word skip length wrong");
   property p_skip_pc;
      tskip |-> ##4 pc_o == PC_W'($past(pc_o, 4) + (skip_active_o ? 32'd1 + 32'(words($past(follow_word_i, 4))) : 32'd1));
   endproperty
   a_skip_pc: assert property (p_skip_pc) else $error("program counter wrong after test");
   property p_xor_done; txor |-> ##4 instr_ready_o && pc_o == PC_W'($past(pc_o, 4) + 1); endproperty
   a_xor_done: assert property (p_xor_done) else $error("xor not finished in one cycle");
   c_skip: cover property (tskip ##4 skip_active_o);
   c_noskip: cover property (tskip ##4 !skip_active_o);
   c_xor: cover property (txor);
endmodule : xor_skip_exec_sva

bind xor_skip_exec xor_skip_exec_sva #(.PC_W(PC_W), .ADR_W(ADR_W)) chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .instr_valid_i(instr_valid_i),
   .instr_i(instr_i), .follow_word_i(follow_word_i), .instr_ready_o(instr_ready_o), .phase_o(phase_o),
   .skip_active_o(skip_active_o), .pc_o(pc_o));

// ---- fetch_model.sv ----
// fetch pipeline stand-in: offers an instruction and its follower until the core takes them
module fetch_model (
   input  wire logic        clk_i,
   input  wire logic        ready_i,
   output logic             valid_o,
   output logic [15:0]      instr_o,
   output logic [15:0]      follow_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      valid_o = 1'b0;
      instr_o = 16'h0000;
      follow_o = 16'h0000;
   end
   // offer after gap + 1 clock edges, hold until ready is seen; idle words are inverted so stale data cannot pass
   task automatic send(input logic [15:0] w, input logic [15:0] f, input int gap);
      repeat (gap + 1) @(posedge clk_i);
      valid_o <= 1'b1;
      instr_o <= w;
      follow_o <= f;
      // waits as long as it takes; the bench watchdog bounds a hang
      do begin
         @(posedge clk_i);
      end while (ready_i !== 1'b1);
      valid_o <= 1'b0;
      instr_o <= ~w;
      follow_o <= ~f;
   endtask : send
endmodule : fetch_model

// ---- tb_top.sv ----
// self-checking bench: bus tasks plus instruction issue through the fetch model
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import xor_skip_pkg::*;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, instr_valid_i, instr_ready_o, skip_active_o;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [15:0] instr_i, follow_word_i, pc_o, ep;
   logic [1:0]  phase_o;
   int          fail_count, checked;
   xor_skip_exec uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .instr_valid_i(instr_valid_i), .instr_i(instr_i), .follow_word_i(follow_word_i),
      .instr_ready_o(instr_ready_o), .phase_o(phase_o), .skip_active_o(skip_active_o), .pc_o(pc_o));
   fetch_model fm (.clk_i(clk_i), .ready_i(instr_ready_o), .valid_o(instr_valid_i), .instr_o(instr_i),
      .follow_o(follow_word_i));
   always #2 clk_i = ~clk_i;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // classic single cycle: hold until ack, take data at that edge, then one idle cycle
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_sel_i <= 4'hf;
      wb_dat_i <= d;
      // no local limit: only the watchdog may end a wait for ack
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask : wb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
      logic [31:0] q;
      wb(1'b0, a, 32'h0, q);
      check(what, q, exp);
   endtask : rd
   // preload data memory through the window: set the address, then write the byte
   task automatic mem(input logic [11:0] a, input logic [7:0] d);
      wr(MADDR_OFS, {20'h0, a});
      wr(MDATA_OFS, {24'h0, d});
   endtask : mem
   // issue one instruction; effects are readable four edges after it is taken
   task automatic run(input logic [15:0] w, input logic [15:0] f, input logic [15:0] inc);
      fm.send(w, f, 0);
      ep += inc;
      repeat (4) @(posedge clk_i);
   endtask : run
   task automatic finish_test();
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      finish_test();
   end
   initial begin
      {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, ep, fail_count, checked} = '0;
      rst_i = 1'b1;
      wb_sel_i = 4'hf;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(PC_OFS, 32'h0, "pc reset");
      rd(8'h20, 32'h0, "unmapped");
      wr(ACC_OFS, 32'hb5);
      run(16'h0aaf, 16'h0000, 16'h1);
      rd(ACC_OFS, 32'h1a, "xor literal");
      rd(STATUS_OFS, 32'h0, "flags clear");
      run(16'h0a1a, 16'h0000, 16'h1);
      rd(STATUS_OFS, 32'h1, "zero flag");
      run(16'h0a80, 16'h0000, 16'h1);
      rd(STATUS_OFS, 32'h2, "negative flag");
      mem(12'h010, 8'haf);
      wr(ACC_OFS, 32'hb5);
      run(16'h1a10, 16'h0000, 16'h1);
      rd(ACC_OFS, 32'hb5, "acc kept");
      rd(MDATA_OFS, 32'h1a, "xor into register");
      wr(BANK_OFS, 32'h2);
      rd(BANK_OFS, 32'h2, "bank pointer");
      mem(12'h210, 8'h0f);
      wr(ACC_OFS, 32'hf0);
      run(16'h1910, 16'h0000, 16'h1);
      rd(ACC_OFS, 32'hff, "banked xor to acc");
      rd(STATUS_OFS, 32'h2, "banked flags");
      mem(12'hf80, 8'h3c);
      wr(ACC_OFS, 32'h3c);
      run(16'h1880, 16'h0000, 16'h1);
      rd(STATUS_OFS, 32'h1, "access bank high");
      wr(CTRL_OFS, 32'h1);
      rd(CTRL_OFS, 32'h1, "extended enable");
      wr(INDEX_OFS, 32'h100);
      rd(INDEX_OFS, 32'h100, "index base");
      mem(12'h15f, 8'h55);
      mem(12'hf60, 8'h11);
      run(16'h185f, 16'h0000, 16'h1);
      rd(ACC_OFS, 32'h55, "indexed at limit");
      run(16'h1860, 16'h0000, 16'h1);
      rd(ACC_OFS, 32'h44, "not indexed above limit");
      wr(CTRL_OFS, 32'h0);
      mem(12'h020, 8'h00);
      mem(12'h220, 8'h00);
      mem(12'h021, 8'h07);
      run(16'h6620, 16'h0000, 16'h2);
      run(16'h6620, 16'hef00, 16'h3);
      run(16'h6720, 16'hc000, 16'h3);
      run(16'h6621, 16'hef00, 16'h1);
      repeat (8) @(posedge clk_i);
      rd(PC_OFS, {16'h0, ep}, "pc after skips");
      wr(PC_OFS, 32'h40);
      rd(PC_OFS, 32'h40, "pc write");
      wr(STATUS_OFS, 32'h3);
      rd(STATUS_OFS, 32'h3, "status write");
      finish_test();
   end
endmodule : tb_top
